// *** hdl/tw_regs.svh ***
/*
  Constants for the table-write execution block: pointer width, holding
  register count, field positions and reset values.
  Assumes inclusion by bare name from the package and from tw_exec.
*/
`ifndef TW_REGS_SVH
`define TW_REGS_SVH

`define TW_PTR_W 21
`define TW_HOLD_N 8
`define TW_HOLD_SEL_W 3
`define TW_BYTE_SEL_BIT 0
`define TW_PTR_RESET 21'h000000
`define TW_LATCH_RESET 8'h00
`define TW_HOLD_RESET 8'hFF
`define TW_INSTR_CYCLES 2

`endif

// *** hdl/tw_pkg.sv ***
/*
  Types shared by the table-write block.
  Assumes tw_regs.svh is on the include path.
*/
`include "tw_regs.svh"

package tw_pkg;

  // ==========================================================
  // Pointer update variant, encoded as in the instruction word
  typedef enum logic [1:0] {
    TW_PTR_KEEP = 2'h0,
    TW_PTR_POST_INC = 2'h1,
    TW_PTR_POST_DEC = 2'h2,
    TW_PTR_PRE_INC = 2'h3
  } tw_mode_t;

  // Phases of the four-phase instruction clock
  typedef enum logic [1:0] {
    TW_Q1,
    TW_Q2,
    TW_Q3,
    TW_Q4
  } tw_phase_t;

  // ==========================================================
  // Write to the holding array
  typedef struct packed {
    logic valid;
    logic [`TW_HOLD_SEL_W-1:0] sel;
    logic high_byte;
    logic [7:0] data;
  } tw_hold_wr_t;

endpackage

// *** hdl/tw_phase_gen.sv ***
/*
  Four-phase instruction clock generator: advances Q1..Q4 each system clock.
  Assumes one system clock per phase.
*/
`timescale 1ns/1ps
`default_nettype none

module tw_phase_gen
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  output var tw_pkg::tw_phase_t phase_o
);

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      phase_o <= tw_pkg::TW_Q1;
    end
    else
    begin
      case (phase_o)
        tw_pkg::TW_Q1: phase_o <= tw_pkg::TW_Q2;
        tw_pkg::TW_Q2: phase_o <= tw_pkg::TW_Q3;
        tw_pkg::TW_Q3: phase_o <= tw_pkg::TW_Q4;
        default: phase_o <= tw_pkg::TW_Q1;
      endcase
    end
  end

endmodule

`default_nettype wire

// *** hdl/tw_exec.sv ***
/*
  Table-write execution: moves the table latch byte into one of the
  programming holding registers chosen by the table pointer, and updates
  the pointer by the instruction's variant.
  Assumes the decoder raises table_write_instr_i for one system clock in
  Q1 of the decode cycle, and holds table_latch_i stable during execution.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tw_regs.svh"

module tw_exec
#(
  parameter int PTR_W = `TW_PTR_W,
  parameter int HOLD_N = `TW_HOLD_N
)
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic table_write_instr_i,
  input wire logic [1:0] mode_i,
  input wire logic [7:0] table_latch_i,
  input wire logic ptr_load_i,
  input wire logic [PTR_W-1:0] ptr_load_val_i,
  output logic [PTR_W-1:0] table_pointer_o,
  output var tw_pkg::tw_phase_t phase_o,
  output logic busy_o,
  output logic hold_we_o,
  output logic [`TW_HOLD_SEL_W-1:0] hold_sel_o,
  output logic hold_high_byte_o,
  output logic [7:0] hold_data_o,
  output logic [HOLD_N*8-1:0] hold_bank_o
);

  // ==========================================================
  // Elaboration checks
  if (PTR_W != `TW_PTR_W)
  begin : g_bad_ptr
    $error("tw_exec: pointer width must be 21");
  end
  if (HOLD_N != `TW_HOLD_N)
  begin : g_bad_hold
    $error("tw_exec: holding register count must be 8");
  end

  // ==========================================================
  // Phase and sequencing
  typedef enum logic [1:0] {
    TW_IDLE,
    TW_CYC1,
    TW_CYC2
  } tw_state_t;

  tw_pkg::tw_phase_t phase;
  tw_state_t state_q;
  tw_pkg::tw_mode_t mode_q;
  logic [PTR_W-1:0] ptr_q;
  logic [7:0] latch_q;
  tw_pkg::tw_hold_wr_t wr_d;
  logic [PTR_W-1:0] one;

  assign one = {{(PTR_W-1){1'b0}}, 1'b1};

  tw_phase_gen u_phase
  (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .phase_o(phase)
  );

  // Two instruction cycles per table write
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= TW_IDLE;
      mode_q <= tw_pkg::TW_PTR_KEEP;
    end
    else
    begin
      case (state_q)
        TW_IDLE:
          if (table_write_instr_i && phase == tw_pkg::TW_Q1)
          begin
            state_q <= TW_CYC1;
            mode_q <= tw_pkg::tw_mode_t'(mode_i);
          end
        TW_CYC1:
          if (phase == tw_pkg::TW_Q4)
          begin
            state_q <= TW_CYC2;
          end
        TW_CYC2:
          if (phase == tw_pkg::TW_Q4)
          begin
            state_q <= TW_IDLE;
          end
        default: state_q <= TW_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Latch capture in Q2 of the second cycle
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      latch_q <= `TW_LATCH_RESET;
    end
    else if (state_q == TW_CYC2 && phase == tw_pkg::TW_Q2)
    begin
      latch_q <= table_latch_i;
    end
  end

  // ==========================================================
  // Table pointer
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ptr_q <= `TW_PTR_RESET;
    end
    else if (state_q == TW_CYC1 && phase == tw_pkg::TW_Q4 &&
             mode_q == tw_pkg::TW_PTR_PRE_INC)
    begin
      ptr_q <= ptr_q + one;
    end
    else if (state_q == TW_CYC2 && phase == tw_pkg::TW_Q4)
    begin
      case (mode_q)
        tw_pkg::TW_PTR_POST_INC: ptr_q <= ptr_q + one;
        tw_pkg::TW_PTR_POST_DEC: ptr_q <= ptr_q - one;
        default: ptr_q <= ptr_q;
      endcase
    end
    else if (ptr_load_i && state_q == TW_IDLE)
    begin
      ptr_q <= ptr_load_val_i;
    end
  end

  // ==========================================================
  // Holding register write in Q4 of the second cycle
  always_comb
  begin
    wr_d.valid = (state_q == TW_CYC2) && (phase == tw_pkg::TW_Q4);
    wr_d.sel = ptr_q[`TW_HOLD_SEL_W-1:0];
    wr_d.high_byte = ptr_q[`TW_BYTE_SEL_BIT];
    wr_d.data = latch_q;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hold_we_o <= 1'b0;
      hold_sel_o <= '0;
      hold_high_byte_o <= 1'b0;
      hold_data_o <= `TW_LATCH_RESET;
    end
    else
    begin
      hold_we_o <= wr_d.valid;
      hold_sel_o <= wr_d.sel;
      hold_high_byte_o <= wr_d.high_byte;
      hold_data_o <= wr_d.data;
    end
  end

  // Holding register array
  genvar gi;
  generate
    for (gi = 0; gi < HOLD_N; gi++)
    begin : g_hold
      always_ff @(posedge sys_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          hold_bank_o[gi*8 +: 8] <= `TW_HOLD_RESET;
        end
        else if (wr_d.valid && wr_d.sel == (`TW_HOLD_SEL_W)'(gi))
        begin
          hold_bank_o[gi*8 +: 8] <= wr_d.data;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Status outputs
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      table_pointer_o <= `TW_PTR_RESET;
      phase_o <= tw_pkg::TW_Q1;
      busy_o <= 1'b0;
    end
    else
    begin
      table_pointer_o <= ptr_q;
      phase_o <= phase;
      busy_o <= (state_q != TW_IDLE);
    end
  end

endmodule

`default_nettype wire

// *** tb/tw_exec_chk.sv ***
/* Assertions on tw_exec ports.
   Assumes starts only while busy_o is low. */
`timescale 1ns/1ps
`default_nettype none
module tw_exec_chk
#(
  parameter int PTR_W = 21,
  parameter int HOLD_N = 8
)
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic table_write_instr_i,
  input wire logic [1:0] mode_i,
  input wire logic [7:0] table_latch_i,
  input wire logic [PTR_W-1:0] table_pointer_o,
  input wire tw_pkg::tw_phase_t phase_o,
  input wire logic busy_o,
  input wire logic hold_we_o,
  input wire logic [2:0] hold_sel_o,
  input wire logic hold_high_byte_o,
  input wire logic [7:0] hold_data_o,
  input wire logic [HOLD_N*8-1:0] hold_bank_o
);
  logic st;
  logic [1:0] m_q;
  logic [PTR_W-1:0] p_q;
  logic [PTR_W-1:0] adr;
  logic [PTR_W-1:0] fin;
  assign st = table_write_instr_i && !busy_o && phase_o == tw_pkg::TW_Q4;
  assign adr = (m_q == 2'h3) ? p_q + 1'b1 : p_q;
  assign fin = (m_q == 2'h0) ? p_q : (m_q == 2'h2) ? p_q - 1'b1 : p_q + 1'b1;
  // ==========
  // Start capture
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      p_q <= '0;
    else if (st)
      p_q <= table_pointer_o;
  end
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      m_q <= 2'h0;
    else if (st)
      m_q <= mode_i;
  end
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_start; st; endsequence
  sequence s_write; (!hold_we_o)[*7] ##1 hold_we_o; endsequence
  property p_time; s_start |=> s_write; endproperty
  property p_sel; hold_we_o |-> hold_sel_o == adr[2:0]; endproperty
  property p_byte; hold_we_o |-> hold_high_byte_o == adr[0]; endproperty
  property p_data; hold_we_o |-> hold_data_o == $past(table_latch_i, 3); endproperty
  property p_bank; hold_we_o |-> hold_bank_o[hold_sel_o*8 +: 8] == hold_data_o; endproperty
  property p_ptr; hold_we_o |=> table_pointer_o == fin; endproperty
  property p_pre;
    s_start ##0 mode_i == 2'h3 |-> ##5 table_pointer_o == $past(table_pointer_o, 5) + 1'b1;
  endproperty
  property p_quiet; $changed(hold_bank_o) |-> hold_we_o; endproperty
  a_time: assert property (p_time)
    else $error("write timing");
  a_sel: assert property (p_sel)
    else $error("sel");
  a_byte: assert property (p_byte)
    else $error("byte");
  a_data: assert property (p_data)
    else $error("data");
  a_bank: assert property (p_bank)
    else $error("bank");
  a_ptr: assert property (p_ptr)
    else $error("ptr");
  a_pre: assert property (p_pre)
    else $error("pre");
  a_quiet: assert property (p_quiet)
    else $error("bank change");
endmodule
bind tw_exec tw_exec_chk #(.PTR_W(PTR_W), .HOLD_N(HOLD_N)) tw_exec_chk_i (
  .sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i),
  .table_write_instr_i(table_write_instr_i),
  .mode_i(mode_i),
  .table_latch_i(table_latch_i),
  .table_pointer_o(table_pointer_o),
  .phase_o(phase_o),
  .busy_o(busy_o),
  .hold_we_o(hold_we_o),
  .hold_sel_o(hold_sel_o),
  .hold_high_byte_o(hold_high_byte_o),
  .hold_data_o(hold_data_o),
  .hold_bank_o(hold_bank_o)
);
`default_nettype wire

// *** tb/test_table_write_execution.sv ***
/* Bench for tw_exec: corner and random table writes.
   Assumes the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module test_table_write_execution;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic [1:0] md = 2'h0;
  logic [7:0] lat = 8'h00;
  logic ld = 1'b0;
  logic [20:0] lv = 21'h000000;
  logic [20:0] ptr;
  tw_pkg::tw_phase_t ph;
  logic busy;
  logic we;
  logic [2:0] sel;
  logic hi;
  logic [7:0] dat;
  logic [63:0] bank;
  logic [63:0] eb = 64'hFFFF_FFFF_FFFF_FFFF;
  int failures = 0;
  int num_checks = 0;
  tw_exec tw_exec_i (.sys_clk_i(clk), .rst_n_i(rst_n), .table_write_instr_i(go),
    .mode_i(md), .table_latch_i(lat), .ptr_load_i(ld), .ptr_load_val_i(lv),
    .table_pointer_o(ptr), .phase_o(ph), .busy_o(busy), .hold_we_o(we),
    .hold_sel_o(sel), .hold_high_byte_o(hi), .hold_data_o(dat), .hold_bank_o(bank));
  always #12.5 clk = ~clk;
  task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic end_of_test();
    if (failures == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic tick();
    @(posedge clk);
    #2;
  endtask
  function automatic logic [20:0] nxt(logic [20:0] p, logic [1:0] m);
    return (m == 2'h0) ? p : (m == 2'h2) ? p - 1'b1 : p + 1'b1;
  endfunction
  // ==========
  // One table write
  task automatic run(logic [20:0] p, logic [1:0] m, logic [7:0] d);
    logic [20:0] a;
    int n;
    a = (m == 2'h3) ? p + 1'b1 : p;
    ld = 1'b1;
    lv = p;
    lat = d;
    tick();
    ld = 1'b0;
    tick();
    chk("ptr load", p, ptr);
    n = 0;
    while (ph !== tw_pkg::TW_Q4 && n < 8)
    begin
      tick();
      n++;
    end
    go = 1'b1;
    md = m;
    tick();
    go = 1'b0;
    // Pointer load while busy must be ignored
    ld = 1'b1;
    lv = ~p;
    n = 0;
    while (we !== 1'b1 && n < 20)
    begin
      tick();
      n++;
    end
    ld = 1'b0;
    eb[a[2:0]*8 +: 8] = d;
    chk("cycles", 7, n);
    chk("busy", 1, busy);
    chk("phase", 2'h3, ph);
    chk("sel", a[2:0], sel);
    chk("byte", a[0], hi);
    chk("data", d, dat);
    chk("bank", eb, bank);
    tick();
    chk("we", 0, we);
    chk("busy idle", 0, busy);
    chk("ptr", nxt(p, m), ptr);
  endtask
  initial
  begin
    void'($urandom(32'hC3E4541B));
    repeat (6) @(posedge clk);
    #2 rst_n = 1'b1;
    run(21'h00A356, 2'h1, 8'h55);
    run(21'h01389A, 2'h3, 8'h34);
    run(21'h1FFFFF, 2'h1, 8'hA5);
    run(21'h000000, 2'h2, 8'h3C);
    run(21'h1FFFFF, 2'h3, 8'h0F);
    run(21'h000007, 2'h0, 8'hC3);
    repeat (40) run(21'($urandom), 2'($urandom), 8'($urandom));
    end_of_test();
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
